// ---- rtl/tpio_pkg.sv ----
/*
  Shared constants and carrier types for the channel four and five pin I/O
  control block: register offsets, control field layout, reset values.
  Assumes a single 200 MHz clock domain and an AHB-Lite master in front.
*/
package tpio_pkg;

  localparam int          TPIO_DATA_W       = 32;
  localparam int          TPIO_CNT_W        = 16;
  localparam int          TPIO_OFS_W        = 8;

  // Register byte offsets
  localparam logic [7:0]  TPIO_OFS_CTRL_FOUR = 8'h00;
  localparam logic [7:0]  TPIO_OFS_CTRL_FIVE = 8'h04;
  localparam logic [7:0]  TPIO_OFS_GRA_FOUR  = 8'h08;
  localparam logic [7:0]  TPIO_OFS_GRA_FIVE  = 8'h0C;
  localparam logic [7:0]  TPIO_OFS_PIN_STAT  = 8'h10;

  // Control field bit positions
  localparam int          TPIO_BIT_MODE      = 3;
  localparam int          TPIO_BIT_SRC       = 2;
  localparam int          TPIO_BIT_EDGE1     = 1;
  localparam int          TPIO_BIT_EDGE0     = 0;

  // Compare actions held in the low two control bits
  localparam logic [1:0]  TPIO_ACT_OFF       = 2'h0;
  localparam logic [1:0]  TPIO_ACT_LOW       = 2'h1;
  localparam logic [1:0]  TPIO_ACT_HIGH      = 2'h2;
  localparam logic [1:0]  TPIO_ACT_TOGGLE    = 2'h3;

  // Reset values
  localparam logic [3:0]  TPIO_CTRL_RST      = 4'h0;
  localparam logic [15:0] TPIO_GRA_RST       = 16'hFFFF;
  localparam logic        TPIO_PIN_RST       = 1'b0;

  // AHB transfer types
  localparam logic [1:0]  TPIO_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic        sel;
    logic [31:0] addr;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
  } tpio_ahb_req_t;

  typedef struct packed {
    logic        out;
    logic        oe_n;
  } tpio_pin_drv_t;

endpackage

// ---- rtl/tpio_sync.sv ----
/*
  Two flip-flop synchroniser for one level from outside the clock domain.
  Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tpio_sync
  import tpio_pkg::*;
(
  input  wire logic clk,      // Block clock
  input  wire logic rst_n,    // Asynchronous reset, active low
  input  wire logic d_async,  // Level from a pin
  output var  logic q_sync    // Level safe to use in clk domain
);

  logic meta_reg;

  // Only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= TPIO_PIN_RST;
      q_sync   <= TPIO_PIN_RST;
    end
    else
    begin
      meta_reg <= d_async;
      q_sync   <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/tpio_channel.sv ----
/*
  One timer channel's general register A with its pin output and capture
  logic. Assumes the pin level is already synchronised and that the match
  and channel-three event strobes are one-cycle pulses on clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tpio_channel
  import tpio_pkg::*;
#(
  parameter bit HAS_CH3_SRC = 1'b0          // Channel-three event source exists
)
(
  input  wire logic                  clk,        // Block clock
  input  wire logic                  rst_n,      // Asynchronous reset, active low
  input  wire logic [3:0]            ctrl,       // Stored control field
  input  wire logic                  ctrl_wr,    // Control written this cycle
  input  wire logic [3:0]            ctrl_wdata, // Control value being written
  input  wire logic                  gra_wr,     // Register A written this cycle
  input  wire logic [TPIO_CNT_W-1:0] gra_wdata,  // Register A write value
  input  wire logic [TPIO_CNT_W-1:0] counter,    // Channel counter value
  input  wire logic                  match,      // Compare match strobe
  input  wire logic                  ch3_event,  // Channel-three register A event
  input  wire logic                  pin_sync,   // Synchronised pin level
  output var  logic [TPIO_CNT_W-1:0] gra,        // General register A
  output var  tpio_pin_drv_t         pin_drv,    // Pin drive and enable
  output var  logic                  capture     // Capture strobe
);

  logic pin_prev_reg;
  logic pin_level_reg;

  wire is_compare = ~ctrl[TPIO_BIT_MODE];
  wire [1:0] act  = ctrl[1:0];
  wire out_on     = is_compare && (act != TPIO_ACT_OFF);
  wire src_ch3    = HAS_CH3_SRC && ctrl[TPIO_BIT_MODE] && ctrl[TPIO_BIT_SRC];
  wire src_pin    = ctrl[TPIO_BIT_MODE] && !src_ch3;
  wire rise       = pin_sync & ~pin_prev_reg;
  wire fall       = ~pin_sync & pin_prev_reg;
  wire both_sel   = ctrl[TPIO_BIT_EDGE1];
  wire pin_edge   = both_sel ? (rise | fall) :
                    (ctrl[TPIO_BIT_EDGE0] ? fall : rise);
  wire cap_now    = (src_pin && pin_edge) || (src_ch3 && ch3_event);
  // Initial level comes from bit 2 of the new code
  wire init_level = ctrl_wdata[TPIO_BIT_SRC];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_prev_reg <= TPIO_PIN_RST;
    else
      pin_prev_reg <= pin_sync;
  end

  // A control write beats a match in the same cycle: new setup starts clean
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_level_reg <= TPIO_PIN_RST;
    else if (ctrl_wr)
      pin_level_reg <= init_level;
    else if (match && is_compare)
    begin
      unique case (act)
        TPIO_ACT_OFF:    pin_level_reg <= pin_level_reg;
        TPIO_ACT_LOW:    pin_level_reg <= 1'b0;
        TPIO_ACT_HIGH:   pin_level_reg <= 1'b1;
        TPIO_ACT_TOGGLE: pin_level_reg <= ~pin_level_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_drv.out  <= TPIO_PIN_RST;
      pin_drv.oe_n <= 1'b1;
    end
    else
    begin
      pin_drv.out  <= pin_level_reg;
      pin_drv.oe_n <= ~out_on;
    end
  end

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gra     <= TPIO_GRA_RST;
      capture <= 1'b0;
    end
    else
    begin
      capture <= cap_now;
      if (cap_now)
        gra <= counter;
      else if (gra_wr)
        gra <= gra_wdata;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/tpio_top.sv ----
/*
  Pin I/O control for general register A of timer channels four and five,
  with an AHB-Lite register slave. Assumes the rest of the timer supplies
  the counters, the compare-match strobes and the channel-three event, and
  that the pads resolve each pin from its output and active-low enable.
*/
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tpio_top
  import tpio_pkg::*;
(
  input  wire logic                   hclk,                   // Clock, 200 MHz
  input  wire logic                   hresetn,                // Asynchronous reset, active low
  input  wire logic                   hsel,                   // AHB slave select
  input  wire logic [31:0]            haddr,                  // AHB address
  input  wire logic [1:0]             htrans,                 // AHB transfer type
  input  wire logic                   hwrite,                 // AHB write
  input  wire logic [2:0]             hsize,                  // AHB size
  input  wire logic [TPIO_DATA_W-1:0] hwdata,                 // AHB write data
  input  wire logic                   hready,                 // AHB bus ready
  output var  logic                   hreadyout,              // AHB slave ready
  output var  logic                   hresp,                  // AHB response, always OKAY
  output var  logic [TPIO_DATA_W-1:0] hrdata,                 // AHB read data
  input  wire logic [TPIO_CNT_W-1:0]  counter_ch_four,        // Channel four counter
  input  wire logic [TPIO_CNT_W-1:0]  counter_ch_five,        // Channel five counter
  input  wire logic                   match_a_ch_four,        // Channel four match strobe
  input  wire logic                   match_a_ch_five,        // Channel five match strobe
  input  wire logic                   ch3_event_a,            // Channel three A event strobe
  input  wire logic                   timer_pin_a_ch_four_i,  // Pin four level in
  output var  logic                   timer_pin_a_ch_four_o,  // Pin four drive level
  output var  logic                   timer_pin_a_ch_four_oe_n, // Pin four enable, active low
  input  wire logic                   timer_pin_a_ch_five_i,  // Pin five level in
  output var  logic                   timer_pin_a_ch_five_o,  // Pin five drive level
  output var  logic                   timer_pin_a_ch_five_oe_n, // Pin five enable, active low
  output var  logic                   capture_a_ch_four,      // Channel four capture strobe
  output var  logic                   capture_a_ch_five       // Channel five capture strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase

  tpio_ahb_req_t req;
  logic                  ph_wr_reg;
  logic [TPIO_OFS_W-1:0] ph_ofs_reg;
  logic [3:0]            pin_io_control_ch_four;
  logic [3:0]            pin_io_control_ch_five;
  logic [TPIO_CNT_W-1:0] general_reg_a_ch_four;
  logic [TPIO_CNT_W-1:0] general_reg_a_ch_five;
  logic                  pin_four_sync;
  logic                  pin_five_sync;
  tpio_pin_drv_t         drv_four;
  tpio_pin_drv_t         drv_five;
  logic                  cap_four;
  logic                  cap_five;
  logic [TPIO_DATA_W-1:0] rd_mux;

  assign req.sel   = hsel;
  assign req.addr  = haddr;
  assign req.trans = htrans;
  assign req.write = hwrite;
  assign req.size  = hsize;

  // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY are ignored
  wire ap_valid = req.sel && req.trans[1] && hready;
  wire [TPIO_OFS_W-1:0] ap_ofs = req.addr[TPIO_OFS_W-1:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_reg  <= 1'b0;
      ph_ofs_reg <= TPIO_OFS_CTRL_FOUR;
    end
    else
    begin
      ph_wr_reg  <= ap_valid && req.write;
      ph_ofs_reg <= ap_ofs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data phase write decode

  wire wr_ctrl_four = ph_wr_reg && (ph_ofs_reg == TPIO_OFS_CTRL_FOUR);
  wire wr_ctrl_five = ph_wr_reg && (ph_ofs_reg == TPIO_OFS_CTRL_FIVE);
  wire wr_gra_four  = ph_wr_reg && (ph_ofs_reg == TPIO_OFS_GRA_FOUR);
  wire wr_gra_five  = ph_wr_reg && (ph_ofs_reg == TPIO_OFS_GRA_FIVE);
  wire [3:0] ctrl_wdata = hwdata[3:0];
  wire [TPIO_CNT_W-1:0] gra_wdata = hwdata[TPIO_CNT_W-1:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_io_control_ch_four <= TPIO_CTRL_RST;
      pin_io_control_ch_five <= TPIO_CTRL_RST;
    end
    else
    begin
      if (wr_ctrl_four)
        pin_io_control_ch_four <= ctrl_wdata;
      if (wr_ctrl_five)
        pin_io_control_ch_five <= ctrl_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  tpio_sync u_sync_four (
    .clk     (hclk),
    .rst_n   (hresetn),
    .d_async (timer_pin_a_ch_four_i),
    .q_sync  (pin_four_sync)
  );

  tpio_sync u_sync_five (
    .clk     (hclk),
    .rst_n   (hresetn),
    .d_async (timer_pin_a_ch_five_i),
    .q_sync  (pin_five_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  tpio_channel #(
    .HAS_CH3_SRC (1'b1)
  ) u_ch_four (
    .clk        (hclk),
    .rst_n      (hresetn),
    .ctrl       (pin_io_control_ch_four),
    .ctrl_wr    (wr_ctrl_four),
    .ctrl_wdata (ctrl_wdata),
    .gra_wr     (wr_gra_four),
    .gra_wdata  (gra_wdata),
    .counter    (counter_ch_four),
    .match      (match_a_ch_four),
    .ch3_event  (ch3_event_a),
    .pin_sync   (pin_four_sync),
    .gra        (general_reg_a_ch_four),
    .pin_drv    (drv_four),
    .capture    (cap_four)
  );

  // Channel five has no foreign capture source
  tpio_channel #(
    .HAS_CH3_SRC (1'b0)
  ) u_ch_five (
    .clk        (hclk),
    .rst_n      (hresetn),
    .ctrl       (pin_io_control_ch_five),
    .ctrl_wr    (wr_ctrl_five),
    .ctrl_wdata (ctrl_wdata),
    .gra_wr     (wr_gra_five),
    .gra_wdata  (gra_wdata),
    .counter    (counter_ch_five),
    .match      (match_a_ch_five),
    .ch3_event  (1'b0),
    .pin_sync   (pin_five_sync),
    .gra        (general_reg_a_ch_five),
    .pin_drv    (drv_five),
    .capture    (cap_five)
  );

  assign timer_pin_a_ch_four_o    = drv_four.out;
  assign timer_pin_a_ch_four_oe_n = drv_four.oe_n;
  assign timer_pin_a_ch_five_o    = drv_five.out;
  assign timer_pin_a_ch_five_oe_n = drv_five.oe_n;
  assign capture_a_ch_four        = cap_four;
  assign capture_a_ch_five        = cap_five;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire sel_ctrl_four = (ap_ofs == TPIO_OFS_CTRL_FOUR);
  wire sel_ctrl_five = (ap_ofs == TPIO_OFS_CTRL_FIVE);
  wire sel_gra_four  = (ap_ofs == TPIO_OFS_GRA_FOUR);
  wire sel_gra_five  = (ap_ofs == TPIO_OFS_GRA_FIVE);
  wire sel_pin_stat  = (ap_ofs == TPIO_OFS_PIN_STAT);

  // Pin status: bit 0/1 pin levels, bit 2/3 drive levels, bit 4/5 enables
  wire [5:0] pin_stat = {~drv_five.oe_n, ~drv_four.oe_n,
                         drv_five.out, drv_four.out,
                         pin_five_sync, pin_four_sync};

  assign rd_mux = sel_ctrl_four ? {28'h0000000, pin_io_control_ch_four} :
                  sel_ctrl_five ? {28'h0000000, pin_io_control_ch_five} :
                  sel_gra_four  ? {16'h0000, general_reg_a_ch_four} :
                  sel_gra_five  ? {16'h0000, general_reg_a_ch_five} :
                  sel_pin_stat  ? {26'h0, pin_stat} :
                  32'h00000000;

  // Read data is sampled at the address phase so it is ready with no wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ap_valid && !req.write)
      hrdata <= rd_mux;
    else
      hrdata <= 32'h00000000;
  end

  // Slave never stalls and never errors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- tb/tpio_assertions.sv ----
/*
  Port-level checks for tpio_top.
  Assumes hready is tied to hreadyout and single word transfers only.
*/
`timescale 1ns/10ps
`default_nettype none

module tpio_assertions
  import tpio_pkg::*;
(
  input wire logic                   hclk,                     // Clock
  input wire logic                   hresetn,                  // Reset, active low
  input wire logic                   hsel,                     // Select
  input wire logic [31:0]            haddr,                    // Address
  input wire logic [1:0]             htrans,                   // Transfer type
  input wire logic                   hwrite,                   // Write
  input wire logic [TPIO_DATA_W-1:0] hwdata,                   // Write data
  input wire logic                   hready,                   // Bus ready
  input wire logic                   hreadyout,                // Slave ready
  input wire logic                   hresp,                    // Response
  input wire logic [TPIO_DATA_W-1:0] hrdata,                   // Read data
  input wire logic                   match_a_ch_four,          // Match four
  input wire logic                   match_a_ch_five,          // Match five
  input wire logic                   ch3_event_a,              // Channel three event
  input wire logic                   timer_pin_a_ch_four_i,    // Pin four in
  input wire logic                   timer_pin_a_ch_five_i,    // Pin five in
  input wire logic                   timer_pin_a_ch_four_o,    // Pin four drive
  input wire logic                   timer_pin_a_ch_five_o,    // Pin five drive
  input wire logic                   timer_pin_a_ch_four_oe_n, // Pin four enable
  input wire logic                   capture_a_ch_four,        // Capture four
  input wire logic                   capture_a_ch_five         // Capture five
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Shadow copies of the control fields, updated at the same edge as the design's
  logic       wr_q;
  logic       rd_q;
  logic [7:0] ofs_q;
  logic [3:0] c4;
  logic [3:0] c5;
  wire  logic en4 = !c4[3] && c4[1:0] != TPIO_ACT_OFF;
  wire  logic take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      ofs_q <= 8'h00;
      c4    <= 4'h0;
      c5    <= 4'h0;
    end
    else
    begin
      wr_q  <= take && hwrite;
      rd_q  <= take && !hwrite;
      ofs_q <= haddr[7:0];
      if (wr_q && ofs_q == TPIO_OFS_CTRL_FOUR)
        c4 <= hwdata[3:0];
      if (wr_q && ofs_q == TPIO_OFS_CTRL_FIVE)
        c5 <= hwdata[3:0];
    end
  end

  sequence m4_low;
    match_a_ch_four && !wr_q && !c4[3] && c4[1:0] == TPIO_ACT_LOW;
  endsequence
  sequence m5_high;
    match_a_ch_five && !wr_q && !c5[3] && c5[1:0] == TPIO_ACT_HIGH;
  endsequence
  sequence m4_tgl;
    match_a_ch_four && !wr_q && !c4[3] && c4[1:0] == TPIO_ACT_TOGGLE;
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  chk_rdata_idle: assert property (!rd_q |-> hrdata == '0)
    else $error("read data outside a read");
  chk_enable_mode: assert property (c4 == $past(c4) |-> timer_pin_a_ch_four_oe_n == !en4)
    else $error("pin four enable wrong for mode");
  chk_init_level: assert property (wr_q && ofs_q == TPIO_OFS_CTRL_FOUR && !hwdata[3]
    |-> ##2 timer_pin_a_ch_four_o == c4[2]) else $error("initial level wrong");
  chk_match_low: assert property (m4_low |-> ##2 !timer_pin_a_ch_four_o)
    else $error("match did not drive low");
  chk_match_high: assert property (m5_high |-> ##2 timer_pin_a_ch_five_o)
    else $error("match did not drive high");
  chk_match_toggle: assert property (m4_tgl
    |-> ##2 timer_pin_a_ch_four_o != $past(timer_pin_a_ch_four_o)) else $error("no toggle");
  // Two sync stages and the edge detector put the strobe three edges after the pin is seen
  chk_cap_rise: assert property ($rose(timer_pin_a_ch_four_i) && c4 == 4'h8
    |-> ##3 capture_a_ch_four) else $error("rising edge not captured");
  chk_cap_fall: assert property ($fell(timer_pin_a_ch_five_i) && c5[3] && c5[1:0] == 2'h1
    |-> ##3 capture_a_ch_five) else $error("falling edge not captured");
  // Strobe flop loads at the same edge as register A
  chk_cap_event: assert property (ch3_event_a && c4[3:2] == 2'h3 |-> ##1 capture_a_ch_four)
    else $error("event not captured");
  chk_cap_mode: assert property (capture_a_ch_four |-> $past(c4[3]))
    else $error("capture in compare mode");
endmodule
`default_nettype wire

// ---- tb/tpio_pin_model.sv ----
/*
  Far side of one timer pin: an outside source and the pad wire.
  Assumes the block drives only while its active-low enable is low.
*/
`timescale 1ns/10ps
`default_nettype none

module tpio_pin_model
(
  input  wire logic drv_o,    // Block drive level
  input  wire logic drv_oe_n, // Block enable, active low
  input  wire logic ext,      // Outside source level
  output wire logic lvl       // Resolved pin level
);
  // The outside source yields while the block drives, so the wire never fights
  assign lvl = drv_oe_n ? ext : drv_o;
endmodule
`default_nettype wire

// ---- tb/tpio_top_tb.sv ----
/*
  Self-checking bench for tpio_top: bus tasks, compare and capture scenarios.
  Assumes one 200 MHz clock and zero-wait bus answers.
*/
`timescale 1ns/10ps
`default_nettype none

module tpio_top_tb;
  import tpio_pkg::*;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] cnt = 16'h0;
  logic        match_a_ch_four = 1'b0;
  logic        match_a_ch_five = 1'b0;
  logic        ch3_event_a = 1'b0;
  logic        ext4 = 1'b0;
  logic        ext5 = 1'b0;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  wire  logic  hreadyout, hresp, capture_a_ch_four, capture_a_ch_five;
  wire  logic  timer_pin_a_ch_four_i, timer_pin_a_ch_four_o, timer_pin_a_ch_four_oe_n;
  wire  logic  timer_pin_a_ch_five_i, timer_pin_a_ch_five_o, timer_pin_a_ch_five_oe_n;
  wire  logic [31:0] hrdata;
  wire  logic  hready = hreadyout;
  wire  logic [1:0] drv4 = {timer_pin_a_ch_four_oe_n, timer_pin_a_ch_four_o};
  wire  logic [1:0] drv5 = {timer_pin_a_ch_five_oe_n, timer_pin_a_ch_five_o};

  tpio_top tpio_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .counter_ch_four(cnt), .counter_ch_five(cnt),
    .match_a_ch_four, .match_a_ch_five, .ch3_event_a, .timer_pin_a_ch_four_i,
    .timer_pin_a_ch_four_o, .timer_pin_a_ch_four_oe_n, .timer_pin_a_ch_five_i,
    .timer_pin_a_ch_five_o, .timer_pin_a_ch_five_oe_n, .capture_a_ch_four, .capture_a_ch_five);
  tpio_pin_model tpio_pin_model_inst (.drv_o(timer_pin_a_ch_four_o),
    .drv_oe_n(timer_pin_a_ch_four_oe_n), .ext(ext4), .lvl(timer_pin_a_ch_four_i));
  tpio_pin_model tpio_pin_model_inst5 (.drv_o(timer_pin_a_ch_five_o),
    .drv_oe_n(timer_pin_a_ch_five_oe_n), .ext(ext5), .lvl(timer_pin_a_ch_five_i));

  always #2.5 hclk = !hclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= TPIO_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    check({30'h0, drv4[1], drv5[1]}, 32'h3);
    ahb(TPIO_OFS_CTRL_FOUR, 1'b0, 32'h0, d);
    check(d, 32'h0);
    ahb(TPIO_OFS_GRA_FIVE, 1'b0, 32'h0, d);
    check(d, {16'h0, TPIO_GRA_RST});
    wr(8'h20, 32'hFFFFFFFF);
    ahb(8'h20, 1'b0, 32'h0, d);
    check(d, 32'h0);
  endtask

  task automatic t_compare();
    logic [3:0] c;
    logic       fin;
    for (int ch = 0; ch < 2; ch++)
      for (int i = 0; i < 8; i++)
      begin
        c = 4'(i);
        fin = c[1:0] == 2'h3 ? !c[2] : c[1:0] == 2'h0 ? c[2] : c[1];
        wr(ch ? TPIO_OFS_CTRL_FIVE : TPIO_OFS_CTRL_FOUR, {28'h0, c});
        repeat (2) @(posedge hclk);
        check({30'h0, ch ? drv5 : drv4}, {30'h0, c[1:0] == 2'h0, c[2]});
        if (ch)
          match_a_ch_five <= 1'b1;
        else
          match_a_ch_four <= 1'b1;
        @(posedge hclk);
        match_a_ch_four <= 1'b0;
        match_a_ch_five <= 1'b0;
        repeat (3) @(posedge hclk);
        check({30'h0, ch ? drv5 : drv4}, {30'h0, c[1:0] == 2'h0, fin});
      end
  endtask

  task automatic pin_step(input logic ch, input logic lv, input logic [15:0] v);
    cnt <= v;
    if (ch)
      ext5 <= lv;
    else
      ext4 <= lv;
    repeat (6) @(posedge hclk);
  endtask

  task automatic t_capture();
    logic [3:0]  codes [7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    logic [31:0] d;
    logic [15:0] ex;
    logic [7:0]  ga;
    foreach (codes[i])
    begin
      ga = codes[i][2] ? TPIO_OFS_GRA_FIVE : TPIO_OFS_GRA_FOUR;
      wr(codes[i][2] ? TPIO_OFS_CTRL_FIVE : TPIO_OFS_CTRL_FOUR, {28'h0, codes[i]});
      pin_step(codes[i][2], 1'b0, 16'h0);
      wr(ga, 32'h0);
      pin_step(codes[i][2], 1'b1, 16'h1230 + 16'(i));
      ahb(ga, 1'b0, 32'h0, d);
      ex = (codes[i][1] || !codes[i][0]) ? 16'h1230 + 16'(i) : 16'h0;
      check(d, {16'h0, ex});
      pin_step(codes[i][2], 1'b0, 16'h4560 + 16'(i));
      ahb(ga, 1'b0, 32'h0, d);
      ex = (codes[i][1] || codes[i][0]) ? 16'h4560 + 16'(i) : ex;
      check(d, {16'h0, ex});
    end
  endtask

  task automatic t_event();
    logic [31:0] d;
    wr(TPIO_OFS_CTRL_FOUR, 32'hC);
    wr(TPIO_OFS_CTRL_FIVE, 32'h8);
    wr(TPIO_OFS_GRA_FIVE, 32'h0);
    cnt <= 16'h7E81;
    ch3_event_a <= 1'b1;
    @(posedge hclk);
    ch3_event_a <= 1'b0;
    @(posedge hclk);
    check({31'h0, capture_a_ch_four}, 32'h1);
    pin_step(1'b0, 1'b1, 16'h1111);
    ahb(TPIO_OFS_GRA_FOUR, 1'b0, 32'h0, d);
    check(d, 32'h7E81);
    ahb(TPIO_OFS_GRA_FIVE, 1'b0, 32'h0, d);
    check(d, 32'h0);
  endtask

  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_compare();
    t_capture();
    t_event();
    end_of_test();
  end
endmodule

bind tpio_top tpio_assertions tpio_assertions_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .match_a_ch_four, .match_a_ch_five,
  .ch3_event_a, .timer_pin_a_ch_four_i, .timer_pin_a_ch_five_i, .timer_pin_a_ch_four_o,
  .timer_pin_a_ch_five_o, .timer_pin_a_ch_four_oe_n, .capture_a_ch_four, .capture_a_ch_five);
`default_nettype wire
